// ### motion_partner.sv
// Motion profile stand-in: answers each move request after a delay
`timescale 1ns/1ps
module motion_partner (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // Request side
    input wire logic       move_req,
    input wire logic [3:0] delay_cycles,
    // Completion
    output logic           motion_done
);
    logic       pend_reg;
    logic [3:0] cnt_reg;

    // One completion per request and never early, so pacing stays ours
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg    <= 1'b0;
            cnt_reg     <= 4'h0;
            motion_done <= 1'b0;
        end else begin
            motion_done <= 1'b0;
            if (move_req) begin
                pend_reg <= 1'b1;
                cnt_reg  <= delay_cycles;
            end else if (pend_reg && cnt_reg == 4'h0) begin
                pend_reg    <= 1'b0;
                motion_done <= 1'b1;
            end else if (pend_reg) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule

// ### point_table_repeat_sequencer.sv
// Point table sequencer: chaining, repeat loops and completion outputs
`timescale 1ns/1ps
module point_table_repeat_sequencer (
    // Clock, reset, enable
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    // Register port
    input  wire logic [seq_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [seq_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [seq_pkg::DATA_W-1:0]   reg_rdata,
    // Controller inputs
    input  wire logic [seq_pkg::TBL_W-1:0]    table_sel,
    input  wire logic                         start,
    input  wire logic                         stop,
    // Motion profile side
    input  wire logic                         motion_done,
    output logic                              move_req,
    output logic      [seq_pkg::DATA_W-1:0]   move_pos,
    output logic                              move_incremental,
    output logic      [seq_pkg::TBL_W-1:0]    move_table,
    // Completion outputs
    output logic                              busy,
    output logic      [seq_pkg::OUT_W-1:0]    table_number_out_bits,
    output logic      [seq_pkg::AUX_W-1:0]    aux_code_out,
    output logic                              table_out_valid
);

    ////////////////////////////////////////////////////////////////////
    // Helper functions

    // Word address of one field of a table entry
    function automatic logic [seq_pkg::MEM_AW-1:0] entry_addr(
        input logic [seq_pkg::TBL_W-1:0] tbl,
        input logic                      word
    );
        entry_addr = {tbl, word};
    endfunction

    // Position data meaning from parameter digit and table code
    function automatic logic is_incremental(
        input logic [seq_pkg::PARAM_W-1:0] param,
        input logic [seq_pkg::SUB_W-1:0]   sub
    );
        is_incremental = (param != seq_pkg::METHOD_ABS) ||
                         sub[seq_pkg::SUB_INC_BIT];
    endfunction

    // Sub-function code field of a fetched control word
    function automatic logic [seq_pkg::SUB_W-1:0] ctl_code(
        input logic [seq_pkg::DATA_W-1:0] word
    );
        ctl_code = word[seq_pkg::SUB_LSB +: seq_pkg::SUB_W];
    endfunction

    // Auxiliary field of a control word; carried along, never decoded
    function automatic logic [seq_pkg::AUX_W-1:0] ctl_aux(
        input logic [seq_pkg::DATA_W-1:0] word
    );
        ctl_aux = word[seq_pkg::AUX_LSB +: seq_pkg::AUX_W];
    endfunction

    // Any state but idle counts as a run in progress
    function automatic logic is_running(
        input seq_pkg::seq_state_e st
    );
        is_running = (st != seq_pkg::ST_IDLE);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Declarations
    tbl_mem_if mif ();

    seq_pkg::seq_state_e           state_reg, state_next;
    logic [seq_pkg::TBL_W-1:0]     start_tbl_reg, start_tbl_next;
    logic [seq_pkg::TBL_W-1:0]     cur_tbl_reg, cur_tbl_next;
    logic [seq_pkg::DATA_W-1:0]    pos_reg, pos_next;
    logic [seq_pkg::SUB_W-1:0]     sub_reg, sub_next;
    logic [seq_pkg::AUX_W-1:0]     aux_reg, aux_next;
    logic                          chained_reg, chained_next;
    logic                          req_reg, req_next;
    logic                          inc_reg, inc_next;
    logic [seq_pkg::OUT_W-1:0]     tout_reg, tout_next;
    logic [seq_pkg::AUX_W-1:0]     aout_reg, aout_next;
    logic                          tvalid_reg, tvalid_next;
    logic [seq_pkg::PARAM_W-1:0]   param_reg, param_next;
    logic [seq_pkg::DATA_W-1:0]    rdata_reg, rdata_next;
    logic                          rmem_reg, rmem_next;
    logic                          in_table;
    logic                          is_loop;
    logic                          is_chain;
    logic [seq_pkg::SUB_W-1:0]     ctl_sub;

    ////////////////////////////////////////////////////////////////////
    // Point table memory
    tbl_mem u_mem (
        .ref_clk (ref_clk),
        .ce      (ce),
        .port    (mif.mem)
    );

    // Bus side of the memory; the table region is a plain word array
    assign in_table = (reg_addr[seq_pkg::REGION_MSB:seq_pkg::REGION_LSB]
                       == seq_pkg::TBL_REGION);
    assign mif.bus_we    = reg_wr && in_table;
    assign mif.bus_addr  = reg_addr[seq_pkg::WORD_MSB:seq_pkg::WORD_LSB];
    assign mif.bus_wdata = reg_wdata;

    ////////////////////////////////////////////////////////////////////
    // Register port: control parameter, status and read return path
    always_comb begin
        param_next = param_reg;
        rdata_next = rdata_reg;
        rmem_next  = rmem_reg;
        if (reg_wr && (reg_addr == seq_pkg::OFF_CTRL)) begin
            param_next = reg_wdata[seq_pkg::PARAM_LSB +: seq_pkg::PARAM_W];
        end
        if (reg_rd) begin
            rmem_next  = in_table;
            rdata_next = '0; // Unmapped addresses read zero
            if (reg_addr == seq_pkg::OFF_CTRL) begin
                rdata_next[seq_pkg::PARAM_LSB +: seq_pkg::PARAM_W] =
                    param_reg;
            end else if (reg_addr == seq_pkg::OFF_STATUS) begin
                rdata_next[seq_pkg::STAT_BUSY]  = is_running(state_reg);
                rdata_next[seq_pkg::STAT_CHAIN] = chained_reg;
                rdata_next[seq_pkg::STAT_TBL_LSB +: seq_pkg::TBL_W] =
                    cur_tbl_reg;
            end
        end
    end

    // Register port flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            param_reg <= seq_pkg::PARAM_RST;
            rdata_reg <= '0;
            rmem_reg  <= 1'b0;
        end else if (ce) begin
            param_reg <= param_next;
            rdata_reg <= rdata_next;
            rmem_reg  <= rmem_next;
        end
    end

    // Both sources are flops; the select only picks one of them
    assign reg_rdata = rmem_reg ? mif.bus_rdata : rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // Sequencer decode of the control word fetched for the current table
    assign ctl_sub  = sub_reg;
    assign is_loop  = ctl_sub[seq_pkg::SUB_LOOP_BIT] &&
                      ((ctl_sub & seq_pkg::SUB_LOOP_MASK) == '0);
    assign is_chain = (ctl_sub == seq_pkg::SUB_CHAIN_ABS) ||
                      (ctl_sub == seq_pkg::SUB_CHAIN_INC);

    // Memory read address follows the fetch state
    always_comb begin
        if (state_reg == seq_pkg::ST_RD_POS) begin
            mif.seq_addr = entry_addr(cur_tbl_reg, seq_pkg::WORD_POS);
        end else begin
            mif.seq_addr = entry_addr(cur_tbl_reg, seq_pkg::WORD_CTL);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_next     = state_reg;
        start_tbl_next = start_tbl_reg;
        cur_tbl_next   = cur_tbl_reg;
        pos_next       = pos_reg;
        sub_next       = sub_reg;
        aux_next       = aux_reg;
        chained_next   = chained_reg;
        req_next       = 1'b0;
        inc_next       = inc_reg;
        tout_next      = tout_reg;
        aout_next      = aout_reg;
        tvalid_next    = tvalid_reg;
        case (state_reg)
            seq_pkg::ST_IDLE: begin
                if (start && !stop && (table_sel != seq_pkg::TABLE_NONE)) begin
                    start_tbl_next = table_sel;
                    cur_tbl_next   = table_sel;
                    chained_next   = 1'b0;
                    tvalid_next    = 1'b0;
                    tout_next      = '0;
                    aout_next      = '0;
                    state_next     = seq_pkg::ST_RD_POS;
                end
            end
            seq_pkg::ST_RD_POS: begin
                state_next = seq_pkg::ST_RD_CTL;
            end
            seq_pkg::ST_RD_CTL: begin
                pos_next   = mif.seq_rdata; // Position word arrives now
                state_next = seq_pkg::ST_ISSUE;
            end
            seq_pkg::ST_ISSUE: begin
                sub_next   = ctl_code(mif.seq_rdata);
                aux_next   = ctl_aux(mif.seq_rdata);
                inc_next   = is_incremental(param_reg,
                                 ctl_code(mif.seq_rdata));
                req_next   = 1'b1;
                state_next = seq_pkg::ST_MOVE;
            end
            seq_pkg::ST_MOVE: begin
                if (motion_done) begin
                    if (is_loop) begin
                        chained_next = 1'b1;
                        state_next   = seq_pkg::ST_RD_POS;
                        if (ctl_sub[seq_pkg::SUB_ONE_BIT]) begin
                            cur_tbl_next = seq_pkg::TABLE_FIRST;
                        end else begin
                            cur_tbl_next = start_tbl_reg;
                        end
                    end else if (is_chain &&
                                 (cur_tbl_reg != seq_pkg::TABLE_LAST)) begin
                        chained_next = 1'b1;
                        cur_tbl_next = cur_tbl_reg + seq_pkg::TABLE_FIRST;
                        state_next   = seq_pkg::ST_RD_POS;
                    end else begin
                        // Codes 0 and 2, unused codes, or a chain code at the last table end the run
                        state_next = seq_pkg::ST_IDLE;
                        if (!chained_reg) begin
                            // Single table: low four table bits only
                            tout_next   = cur_tbl_reg[seq_pkg::OUT_W-1:0];
                            aout_next   = aux_reg;
                            tvalid_next = 1'b1;
                        end
                    end
                end
            end
            default: begin
                state_next = seq_pkg::ST_IDLE;
            end
        endcase
        // Stop wins over the next state and the move request and ends any loop
        if (stop) begin
            state_next = seq_pkg::ST_IDLE;
            req_next   = 1'b0;
        end
    end

    // Sequencer flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= seq_pkg::ST_IDLE;
            start_tbl_reg <= seq_pkg::TABLE_NONE;
            cur_tbl_reg   <= seq_pkg::TABLE_NONE;
            pos_reg       <= '0;
            sub_reg       <= seq_pkg::SUB_END_ABS;
            aux_reg       <= '0;
            chained_reg   <= 1'b0;
            req_reg       <= 1'b0;
            inc_reg       <= 1'b0;
            tout_reg      <= '0;
            aout_reg      <= '0;
            tvalid_reg    <= 1'b0;
        end else if (ce) begin
            state_reg     <= state_next;
            start_tbl_reg <= start_tbl_next;
            cur_tbl_reg   <= cur_tbl_next;
            pos_reg       <= pos_next;
            sub_reg       <= sub_next;
            aux_reg       <= aux_next;
            chained_reg   <= chained_next;
            req_reg       <= req_next;
            inc_reg       <= inc_next;
            tout_reg      <= tout_next;
            aout_reg      <= aout_next;
            tvalid_reg    <= tvalid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs; completion outputs are cleared at every start, so they
    // never show a value while a chain or loop runs
    assign move_req              = req_reg;
    assign move_pos              = pos_reg;
    assign move_incremental      = inc_reg;
    assign move_table            = cur_tbl_reg;
    assign busy                  = is_running(state_reg);
    assign table_number_out_bits = tout_reg;
    assign aux_code_out          = aout_reg;
    assign table_out_valid       = tvalid_reg;

endmodule

// ### seq_checker_assertions.sv
// Port-level assertions for the point table sequencer
`timescale 1ns/1ps
module seq_checker (
    // Clock, reset, enable
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic                       ce,
    // Register port
    input wire logic [seq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                       reg_rd,
    input wire logic [seq_pkg::DATA_W-1:0] reg_rdata,
    // Controller and motion side
    input wire logic [seq_pkg::TBL_W-1:0]  table_sel,
    input wire logic                       start,
    input wire logic                       stop,
    input wire logic                       motion_done,
    input wire logic                       move_req,
    input wire logic [seq_pkg::TBL_W-1:0]  move_table,
    // Completion outputs
    input wire logic                       busy,
    input wire logic [seq_pkg::OUT_W-1:0]  table_number_out_bits,
    input wire logic [seq_pkg::AUX_W-1:0]  aux_code_out,
    input wire logic                       table_out_valid
);
    logic wait_reg;
    logic wait_next;
    logic done_ok;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // A completion counts only while a move is outstanding
    assign done_ok = ce & motion_done & (wait_reg | move_req);
    always_comb begin
        wait_next = ce ? (wait_reg | move_req) & ~motion_done & ~stop
                       : wait_reg;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= wait_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    move_pulse_a: assert property (move_req && ce |=> !move_req)
        else $error("move request longer than one cycle");
    start_fetch_a: assert property (
        !busy && ce && start && !stop && table_sel != 5'h00
        ##1 (ce && !stop)[*3] |=> move_req && move_table == $past(table_sel, 4))
        else $error("start did not issue selected table in time");
    quiet_chain_a: assert property (busy |-> !table_out_valid
        && table_number_out_bits == 4'h0 && aux_code_out == 8'h00)
        else $error("completion outputs driven during run");
    stop_idle_a: assert property (stop && ce |=> !busy && !move_req)
        else $error("stop did not force idle");
    req_busy_a: assert property (move_req |-> busy)
        else $error("move request while idle");
    done_bits_a: assert property ($rose(table_out_valid) |-> $fell(busy)
        && table_number_out_bits == move_table[3:0])
        else $error("completion bits wrong");
    end_cause_a: assert property (
        $fell(busy) && !$past(stop) |-> $past(done_ok))
        else $error("run ended without completion");
    chain_next_a: assert property (
        done_ok && !stop ##1 (busy && ce && !stop)[*3] |=> move_req)
        else $error("chained table not issued in time");
    status_busy_a: assert property (
        reg_rd && ce && reg_addr == seq_pkg::OFF_STATUS
        |=> reg_rdata[seq_pkg::STAT_BUSY] == $past(busy))
        else $error("status busy bit wrong");
endmodule

bind point_table_repeat_sequencer seq_checker u_seq_checker (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .table_sel(table_sel),
    .start(start), .stop(stop), .motion_done(motion_done),
    .move_req(move_req), .move_table(move_table), .busy(busy),
    .table_number_out_bits(table_number_out_bits),
    .aux_code_out(aux_code_out), .table_out_valid(table_out_valid)
);

// ### seq_pkg.sv
// Shared constants and types for the point table repeat sequencer
package seq_pkg;

    // Bus and memory geometry
    localparam int ADDR_W  = 10;
    localparam int DATA_W  = 32;
    localparam int TBL_W   = 5;
    localparam int MEM_AW  = 6;
    localparam int OUT_W   = 4;
    localparam int AUX_W   = 8;
    localparam int SUB_W   = 4;
    localparam int PARAM_W = 4;

    // Register map
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 10'h000;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 10'h004;
    localparam logic [1:0]        TBL_REGION = 2'h1;
    localparam int                REGION_MSB = 9;
    localparam int                REGION_LSB = 8;
    localparam int                WORD_MSB   = 7;
    localparam int                WORD_LSB   = 2;

    // Table entry layout: word 0 position, word 1 control
    localparam logic WORD_POS = 1'b0;
    localparam logic WORD_CTL = 1'b1;
    localparam int   SUB_LSB  = 0;
    localparam int   AUX_LSB  = 8;

    // Control and status fields
    localparam int PARAM_LSB    = 0;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_CHAIN   = 1;
    localparam int STAT_TBL_LSB = 8;
    localparam logic [PARAM_W-1:0] PARAM_RST  = 4'h0;
    localparam logic [PARAM_W-1:0] METHOD_ABS = 4'h0;

    // Sub-function codes
    localparam logic [SUB_W-1:0] SUB_END_ABS   = 4'h0;
    localparam logic [SUB_W-1:0] SUB_CHAIN_ABS = 4'h1;
    localparam logic [SUB_W-1:0] SUB_END_INC   = 4'h2;
    localparam logic [SUB_W-1:0] SUB_CHAIN_INC = 4'h3;
    localparam int               SUB_LOOP_BIT  = 3;
    localparam int               SUB_ONE_BIT   = 0;
    localparam int               SUB_INC_BIT   = 1;
    localparam logic [SUB_W-1:0] SUB_LOOP_MASK = 4'h4;

    // Table numbers
    localparam logic [TBL_W-1:0] TABLE_NONE  = 5'h00;
    localparam logic [TBL_W-1:0] TABLE_FIRST = 5'h01;
    localparam logic [TBL_W-1:0] TABLE_LAST  = 5'h1f;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_POS,
        ST_RD_CTL,
        ST_ISSUE,
        ST_MOVE
    } seq_state_e;

endpackage

// ### tbl_mem.sv
// Point table memory with one bus port and one sequencer read port
`timescale 1ns/1ps
module tbl_mem (
    // Clocking
    input wire logic ref_clk,
    input wire logic ce,
    // Memory ports
    tbl_mem_if.mem   port
);
    localparam int DEPTH = 1 << seq_pkg::MEM_AW;

    logic [seq_pkg::DATA_W-1:0] mem_q [DEPTH];

    ////////////////////////////////////////////////////////////////////
    // Storage and registered reads; no reset so it maps to RAM
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            if (port.bus_we) begin
                mem_q[port.bus_addr] <= port.bus_wdata;
            end
            port.bus_rdata <= mem_q[port.bus_addr];
            port.seq_rdata <= mem_q[port.seq_addr];
        end
    end
endmodule

// ### tbl_mem_if.sv
// Carrier between the sequencer and its point table memory
`timescale 1ns/1ps
interface tbl_mem_if;
    logic                      bus_we;
    logic [seq_pkg::MEM_AW-1:0] bus_addr;
    logic [seq_pkg::DATA_W-1:0] bus_wdata;
    logic [seq_pkg::DATA_W-1:0] bus_rdata;
    logic [seq_pkg::MEM_AW-1:0] seq_addr;
    logic [seq_pkg::DATA_W-1:0] seq_rdata;

    modport ctrl (
        output bus_we, bus_addr, bus_wdata, seq_addr,
        input  bus_rdata, seq_rdata
    );
    modport mem (
        input  bus_we, bus_addr, bus_wdata, seq_addr,
        output bus_rdata, seq_rdata
    );
endinterface

// ### testbench.sv
// Self-checking testbench for the point table sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
        num_errors++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module testbench;
    typedef struct {
        logic [3:0]  param;
        logic [15:0] codes;
        logic [4:0]  first;
        logic [3:0]  dly;
        logic [3:0]  bits;
    } row_s;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic [9:0]  reg_addr = 10'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [4:0]  table_sel = 5'h00;
    logic        start = 1'b0;
    logic        stop = 1'b0;
    logic        motion_done;
    logic        move_req;
    logic [31:0] move_pos;
    logic        move_incremental;
    logic [4:0]  move_table;
    logic        busy;
    logic [3:0]  table_number_out_bits;
    logic [7:0]  aux_code_out;
    logic        table_out_valid;
    logic [3:0]  dly = 4'h0;
    int          num_errors = 0;
    int          samples_checked = 0;

    // Codes four bits per table, table 1 lowest; rows 0 to 3 loop until stopped, the others end in 0 or 2
    row_s rows [8] = '{
        '{4'h0, 16'h8311, 5'h02, 4'h0, 4'h0},
        '{4'h0, 16'h0911, 5'h02, 4'h5, 4'h0},
        '{4'h0, 16'ha131, 5'h02, 4'h0, 4'h0},
        '{4'h0, 16'h0b13, 5'h02, 4'h5, 4'h0},
        '{4'h0, 16'h0000, 5'h01, 4'h0, 4'h1},
        '{4'h0, 16'h0021, 5'h01, 4'h5, 4'h0},
        '{4'h1, 16'h0000, 5'h03, 4'h0, 4'h3},
        '{4'h0, 16'h2000, 5'h04, 4'h5, 4'h4}
    };

    ////////////////////////////////////////////////////////////////////////
    point_table_repeat_sequencer u_point_table_repeat_sequencer (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .table_sel(table_sel), .start(start),
        .stop(stop), .motion_done(motion_done), .move_req(move_req),
        .move_pos(move_pos), .move_incremental(move_incremental),
        .move_table(move_table), .busy(busy),
        .table_number_out_bits(table_number_out_bits),
        .aux_code_out(aux_code_out), .table_out_valid(table_out_valid));
    motion_partner u_motion_partner (
        .ref_clk(ref_clk), .rst_n(rst_n), .move_req(move_req),
        .delay_cycles(dly), .motion_done(motion_done));

    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Table n sits at 0x100 + 8n, control word four bytes up
    function automatic logic [9:0] taddr(input int n, input logic w);
        return 10'h100 + 10'(8 * n) + (w ? 10'h004 : 10'h000);
    endfunction

    // Next table as the codes define it; zero means the run ends
    function automatic logic [4:0] nxt(input logic [3:0] c,
                                       input logic [4:0] t, s);
        case (c)
            4'h1, 4'h3: return t + 5'h01;
            4'h8, 4'ha: return s;
            4'h9, 4'hb: return 5'h01;
            default: return 5'h00;
        endcase
    endfunction

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic go(input logic [4:0] sel);
        @(posedge ref_clk);
        table_sel <= sel;
        start     <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
    endtask

    // Bounded wait for a move request, or for the run to end
    task automatic wait_sig(input logic want_move);
        for (int w = 0; w < 60; w++) begin
            @(posedge ref_clk);
            #1;
            if (want_move ? move_req === 1'b1 : busy === 1'b0) return;
        end
        num_errors++;
        give_verdict();
    endtask

    task automatic run_row(input row_s r);
        logic [4:0]  t;
        logic [3:0]  c;
        logic        chain;
        logic [31:0] d;
        chain = 1'b0;
        wr(seq_pkg::OFF_CTRL, {28'h0, r.param});
        rd(seq_pkg::OFF_CTRL, d);
        `CHK("param_rb", {28'h0, r.param}, d)
        for (int k = 1; k < 5; k++) begin
            wr(taddr(k, 1'b0), 32'ha000_0000 + k);
            wr(taddr(k, 1'b1), {16'h0, 8'h10 + 8'(k), 4'h0,
                r.codes[4*(k-1) +: 4]});
        end
        dly <= r.dly;
        go(r.first);
        t = r.first;
        for (int k = 0; k < 7 && t != 5'h00; k++) begin
            wait_sig(1'b1);
            c = r.codes[4*(t-1) +: 4];
            `CHK("move_table", t, move_table)
            `CHK("move_pos", 32'ha000_0000 + t, move_pos)
            `CHK("move_inc", (r.param != 4'h0) | c[1], move_incremental)
            `CHK("quiet", 1'b0, table_out_valid)
            t = nxt(c, t, r.first);
            chain = chain | (t != 5'h00);
        end
        if (t != 5'h00) begin
            rd(seq_pkg::OFF_STATUS, d);
            `CHK("status_busy", 1'b1, d[seq_pkg::STAT_BUSY])
            `CHK("status_chain", 1'b1, d[seq_pkg::STAT_CHAIN])
            @(posedge ref_clk);
            stop <= 1'b1;
            @(posedge ref_clk);
            stop <= 1'b0;
            #1;
            `CHK("stop_busy", 1'b0, busy)
        end else begin
            wait_sig(1'b0);
            `CHK("done_valid", !chain, table_out_valid)
            `CHK("done_bits", r.bits, table_number_out_bits)
            `CHK("done_aux", chain ? 8'h00 : 8'h10 + 8'(r.first),
                aux_code_out)
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset first, then the row loop, readbacks, refusals and a mid-run reset by hand
    initial begin
        logic [31:0] d;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        `CHK("reset_quiet", 1'b0, busy | move_req | table_out_valid)
        for (int i = 0; i < 8; i++) begin
            run_row(rows[i]);
        end
        rd(10'h3fc, d);
        `CHK("unmapped", 32'h0, d)
        rd(taddr(4, 1'b1), d);
        `CHK("aux_store", 32'h0000_1402, d)
        @(posedge ref_clk);
        ce <= 1'b0;
        go(5'h01);
        ce <= 1'b1;
        @(posedge ref_clk);
        #1;
        `CHK("frozen_start", 1'b0, busy)
        go(5'h00);
        @(posedge ref_clk);
        #1;
        `CHK("zero_start", 1'b0, busy)
        go(5'h04);
        wait_sig(1'b1);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("mid_reset", 1'b0, busy | move_req)
        rst_n <= 1'b1;
        give_verdict();
    end
endmodule
